// ==== sim/core_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module core_model (
    input  wire logic       mclk_i,
    input  wire logic       play_valid_i,
    input  wire logic [7:0] play_data_i,
    output logic            play_ready_o,
    output logic            cap_valid_o,
    output logic [7:0]      cap_data_o,
    input  wire logic       cap_ready_i
);
    logic       stall;
    logic       cap_on;
    logic [7:0] cap_cnt;
    logic [7:0] got[$];
    // Stale capture data shows inverted so an old byte never matches
    assign play_ready_o = !stall;
    assign cap_valid_o  = cap_on;
    assign cap_data_o   = cap_on ? cap_cnt : ~cap_cnt;
    initial begin
        stall   = 1'b0;
        cap_on  = 1'b0;
        cap_cnt = 8'h30;
    end
    // One byte per arming; it is gone once consumed
    always @(posedge mclk_i) begin
        if (play_valid_i === 1'b1 && !stall) got.push_back(play_data_i);
        if (cap_ready_i === 1'b1) begin
            cap_cnt <= cap_cnt + 8'h01;
            cap_on  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    localparam logic [11:0] BASE = 12'h530;
    logic        mclk_i, rst_b_i, aen, ior_b, iow_b, cint, cerr, pv, pr, cv, cr, oe;
    logic [11:0] sa;
    logic [7:0]  sd, sdo, pd, cd, pf, cf, rd;
    logic [1:0]  dack_b, drq;
    int          fail_count, comparisons, cycles;
    codec_host_port dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .codec_port_base_i(BASE),
        .sa_i(sa), .aen_i(aen), .ior_b_i(ior_b), .iow_b_i(iow_b), .sd_i(sd), .sd_o(sdo),
        .sd_oe_o(oe), .dack_b_i(dack_b), .drq_o(drq), .play_data_o(pd), .play_valid_o(pv),
        .play_ready_i(pr), .cap_data_i(cd), .cap_valid_i(cv), .cap_ready_o(cr),
        .core_int_i(cint), .core_err_i(cerr), .play_fmt_o(pf), .cap_fmt_o(cf));
    core_model core_u (.mclk_i(mclk_i), .play_valid_i(pv), .play_data_i(pd),
        .play_ready_o(pr), .cap_valid_o(cv), .cap_data_o(cd), .cap_ready_i(cr));
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic io_wr(input logic [1:0] ofs, input logic [7:0] d);
        sa = BASE + {10'h000, ofs};
        sd = d;
        iow_b = 1'b0;
        step(4);
        iow_b = 1'b1;
        step(1);
        sd = ~d;
        step(4);
    endtask
    task automatic io_rd(input logic [1:0] ofs, output logic [7:0] d);
        sa = BASE + {10'h000, ofs};
        ior_b = 1'b0;
        step(5);
        `CHK(oe, 1'b1)
        d = sdo;
        ior_b = 1'b1;
        step(4);
    endtask
    // Reserved bits are always written as zero by every caller
    task automatic iw(input logic [4:0] i, input logic [7:0] d);
        io_wr(creg_pkg::OFS_INDEX, {3'h0, i});
        io_wr(creg_pkg::OFS_WINDOW, d);
    endtask
    task automatic ir(input logic [4:0] i, output logic [7:0] d);
        io_wr(creg_pkg::OFS_INDEX, {3'h0, i});
        io_rd(creg_pkg::OFS_WINDOW, d);
    endtask
    task automatic dma(input int k, input logic wr, input logic [7:0] d, output logic [7:0] q);
        aen = 1'b1;
        dack_b[k] = 1'b0;
        sd = d;
        if (wr) iow_b = 1'b0;
        else ior_b = 1'b0;
        step(5);
        q = sdo;
        iow_b = 1'b1;
        ior_b = 1'b1;
        step(3);
        dack_b = 2'b11;
        aen = 1'b0;
        sd = ~d;
        step(4);
    endtask
    task automatic wait_drq(input int k, input logic e);
        int n;
        n = 0;
        while (drq[k] !== e && n < 40) begin
            step(1);
            n++;
        end
        `CHK(drq[k], e)
    endtask
    task automatic t_regs();
        io_rd(creg_pkg::OFS_INDEX, rd);
        `CHK(rd, 8'h00)
        ir(creg_pkg::IDX_MODE, rd);
        `CHK(rd, {3'b100, 1'b0, creg_pkg::CODEC_ID})
        iw(5'h00, 8'h4a);
        iw(5'h11, 8'h2c);
        ir(5'h00, rd);
        `CHK(rd, 8'h4a)
        ir(5'h01, rd);
        `CHK(rd, 8'h2c)
        iw(5'h19, 8'h80);
        ir(creg_pkg::IDX_IFACE, rd);
        `CHK(rd, 8'h80)
    endtask
    task automatic t_modes();
        iw(creg_pkg::IDX_MODE, 8'h40);
        ir(creg_pkg::IDX_COMPAT, rd);
        `CHK(rd, creg_pkg::COMPAT_ID)
        iw(creg_pkg::IDX_EXT, 8'ha0);
        ir(creg_pkg::IDX_EXT, rd);
        `CHK(rd, 8'h00)
        iw(creg_pkg::IDX_CAPFMT, 8'h40);
        step(2);
        `CHK(cf, 8'h40)
        `CHK(pf, 8'h00)
        iw(creg_pkg::IDX_MODE, 8'h60);
        ir(creg_pkg::IDX_MODE, rd);
        `CHK(rd, {3'b111, 1'b0, creg_pkg::CODEC_ID})
        iw(creg_pkg::IDX_EXT, 8'ha0);
        ir(creg_pkg::IDX_EXT, rd);
        `CHK(rd, 8'ha0)
        iw(creg_pkg::IDX_MODE, 8'h00);
        step(2);
        `CHK(cf, 8'h00)
    endtask
    task automatic t_dma();
        core_u.cap_on = 1'b1;
        iw(creg_pkg::IDX_IFACE, 8'h02);
        wait_drq(1, 1'b1);
        `CHK(drq[0], 1'b0)
        dma(1, 1'b0, 8'h00, rd);
        `CHK(rd, 8'h30)
        wait_drq(1, 1'b0);
        iw(creg_pkg::IDX_IFACE, 8'h06);
        core_u.cap_on = 1'b1;
        wait_drq(0, 1'b1);
        `CHK(drq[1], 1'b0)
        dma(0, 1'b0, 8'h00, rd);
        `CHK(rd, 8'h31)
        iw(creg_pkg::IDX_IFACE, 8'h04);
        core_u.cap_on = 1'b1;
        iw(creg_pkg::IDX_IFACE, 8'h07);
        wait_drq(0, 1'b1);
        `CHK(drq[1], 1'b0)
        dma(0, 1'b1, 8'h77, rd);
        `CHK(core_u.cap_on, 1'b1)
        `CHK(core_u.got[0], 8'h77)
        iw(creg_pkg::IDX_IFACE, 8'h06);
        step(4);
        `CHK(drq[0], 1'b1)
        dma(0, 1'b1, 8'h78, rd);
        wait_drq(0, 1'b1);
        dma(0, 1'b0, 8'h00, rd);
        `CHK(rd, 8'h32)
    endtask
    task automatic t_pio();
        iw(creg_pkg::IDX_IFACE, 8'h04);
        core_u.got.delete();
        core_u.stall = 1'b1;
        io_wr(creg_pkg::OFS_PIO, 8'h11);
        io_wr(creg_pkg::OFS_PIO, 8'h22);
        io_wr(creg_pkg::OFS_PIO, 8'h33);
        io_rd(creg_pkg::OFS_STATUS, rd);
        `CHK(rd[1], 1'b0)
        core_u.stall = 1'b0;
        cint = 1'b1;
        cerr = 1'b1;
        step(10);
        `CHK(core_u.got.size(), 2)
        `CHK({core_u.got[0], core_u.got[1]}, 16'h1122)
        io_rd(creg_pkg::OFS_STATUS, rd);
        `CHK(rd[1:0], 2'b11)
        `CHK(rd[4], 1'b1)
        core_u.cap_on = 1'b1;
        io_rd(creg_pkg::OFS_PIO, rd);
        `CHK(rd, 8'h33)
        step(2);
        `CHK(core_u.cap_on, 1'b0)
    endtask
    task automatic report_and_stop();
        $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    // Whole sequence needs well under a thousand cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            report_and_stop();
        end
    end
    initial begin
        {aen, cint, cerr, dack_b, ior_b, iow_b} = 7'h0f;
        {sa, sd, rst_b_i} = 21'h0;
        repeat (4) @(posedge mclk_i);
        #1;
        rst_b_i = 1'b1;
        step(2);
        t_regs();
        t_modes();
        t_dma();
        t_pio();
        report_and_stop();
    end
endmodule
`default_nettype wire

// ==== verilog/codec_host_port.sv ====
`timescale 1ns/100ps
`default_nettype none
module codec_host_port (
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    input  wire logic [11:0] codec_port_base_i,
    input  wire logic [11:0] sa_i,
    input  wire logic        aen_i,
    input  wire logic        ior_b_i,
    input  wire logic        iow_b_i,
    input  wire logic [7:0]  sd_i,
    output logic      [7:0]  sd_o,
    output logic             sd_oe_o,
    input  wire logic [1:0]  dack_b_i,
    output logic      [1:0]  drq_o,
    output logic      [7:0]  play_data_o,
    output logic             play_valid_o,
    input  wire logic        play_ready_i,
    input  wire logic [7:0]  cap_data_i,
    input  wire logic        cap_valid_i,
    output logic             cap_ready_o,
    input  wire logic        core_int_i,
    input  wire logic        core_err_i,
    output logic      [7:0]  play_fmt_o,
    output logic      [7:0]  cap_fmt_o
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [24:0] pin_meta_ff;
    logic [24:0] pin_sync_ff;
    wire  [24:0] pin_raw = {dack_b_i, sd_i, iow_b_i, ior_b_i, aen_i, sa_i};

    always_ff @(posedge mclk_i) begin
        pin_meta_ff <= pin_raw;
        pin_sync_ff <= pin_meta_ff;
    end

    wire [11:0] sa_s     = pin_sync_ff[11:0];
    wire        aen_s    = pin_sync_ff[12];
    wire        ior_b_s  = pin_sync_ff[13];
    wire        iow_b_s  = pin_sync_ff[14];
    wire [7:0]  sd_s     = pin_sync_ff[22:15];
    wire [1:0]  dack_b_s = pin_sync_ff[24:23];

    // ----------------------------------------
    // Strobe edges and cycle capture
    // ----------------------------------------
    logic       ior_b_d_ff;
    logic       iow_b_d_ff;
    logic       cyc_hit_ff;
    logic [1:0] cyc_ofs_ff;
    logic [1:0] cyc_dack_ff;
    logic [7:0] cyc_data_ff;

    // Writes land on the trailing edge of the strobe, as on the bus
    wire wr_rise    = iow_b_s & ~iow_b_d_ff;
    wire rd_rise    = ior_b_s & ~ior_b_d_ff;
    wire strobe_low = ~ior_b_s | ~iow_b_s;
    // DMA cycles carry AEN high, so address decode drops out by itself
    wire hit_now    = ~aen_s & (sa_s[11:2] == codec_port_base_i[11:2]);
    wire [1:0] ofs_now = sa_s[1:0];

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            ior_b_d_ff  <= 1'b1;
            iow_b_d_ff  <= 1'b1;
            cyc_hit_ff  <= 1'b0;
            cyc_ofs_ff  <= 2'h0;
            cyc_dack_ff <= 2'h0;
            cyc_data_ff <= 8'h00;
        end else begin
            ior_b_d_ff <= ior_b_s;
            iow_b_d_ff <= iow_b_s;
            if (strobe_low) begin
                cyc_hit_ff  <= hit_now;
                cyc_ofs_ff  <= ofs_now;
                cyc_dack_ff <= ~dack_b_s;
                cyc_data_ff <= sd_s;
            end
        end
    end

    wire wr_reg = wr_rise & cyc_hit_ff;
    wire rd_reg = rd_rise & cyc_hit_ff;
    wire wr_ptr = wr_reg & (cyc_ofs_ff == creg_pkg::OFS_INDEX);
    wire wr_win = wr_reg & (cyc_ofs_ff == creg_pkg::OFS_WINDOW);
    wire wr_pio = wr_reg & (cyc_ofs_ff == creg_pkg::OFS_PIO);
    wire rd_pio = rd_reg & (cyc_ofs_ff == creg_pkg::OFS_PIO);

    // ----------------------------------------
    // Index pointer and indirect registers
    // ----------------------------------------
    logic [6:0] r0_ff;
    logic [7:0] regs_ff [32];

    wire [7:0] mode_reg  = regs_ff[creg_pkg::IDX_MODE];
    wire [7:0] iface     = regs_ff[creg_pkg::IDX_IFACE];
    creg_pkg::compat_mode_select_e cms;
    assign cms = creg_pkg::compat_mode_select_e'(mode_reg[creg_pkg::CMS_MSB:creg_pkg::CMS_LSB]);

    // Mode field 01 has no meaning; it behaves like mode 1
    wire mode1 = (cms == creg_pkg::CMS_MODE1) | (cms == creg_pkg::CMS_SPARE);
    wire mode3 = (cms == creg_pkg::CMS_MODE3);

    // Top index bit is not decoded in mode 1
    wire [4:0] eff_idx = mode1 ? {1'b0, r0_ff[3:0]} : r0_ff[4:0];

    wire ext_hidden = (eff_idx == creg_pkg::IDX_EXT) & ~mode3;
    wire ro_idx = (eff_idx == creg_pkg::IDX_COMPAT) | (eff_idx == creg_pkg::IDX_RSV27)
                | (eff_idx == creg_pkg::IDX_RSV29) | ext_hidden;
    wire reg_we = wr_win & ~ro_idx;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            r0_ff <= creg_pkg::R0_RST;
        end else if (wr_ptr) begin
            r0_ff <= cyc_data_ff[6:0];
        end
    end

    // Reset clears the mode field, so the port starts in mode 1
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < 32; i++) begin
                regs_ff[i] <= creg_pkg::REG_RST;
            end
        end else if (reg_we) begin
            regs_ff[eff_idx] <= cyc_data_ff;
        end
    end

    // ----------------------------------------
    // Interface configuration decode
    // ----------------------------------------
    wire single    = iface[creg_pkg::IFC_SDC];
    // PIO select bits take a direction off DMA whatever the channel mode
    wire play_want = iface[creg_pkg::IFC_PEN] & ~iface[creg_pkg::IFC_PLAYBACK_BY_PROGRAMMED_IO];
    // A byte whose ready pulse is out is spent; starting on it would park a channel
    wire cap_avail = cap_valid_i & ~cap_ready_o;
    wire cap_want  = iface[creg_pkg::IFC_CEN] & ~iface[creg_pkg::IFC_CAPTURE_BY_PROGRAMMED_IO] & cap_avail;

    function automatic logic [2:0] sample_bytes(input logic [7:0] fmt);
        logic wide;
        wide = (fmt[creg_pkg::FMT_HI:creg_pkg::FMT_LO] == 2'b11)
             | ((fmt[creg_pkg::FMT_HI:creg_pkg::FMT_LO] == 2'b01) & ~fmt[creg_pkg::FMT_CL]);
        case ({wide, fmt[creg_pkg::FMT_SM]})
            2'b00:   sample_bytes = 3'h1;
            2'b01:   sample_bytes = 3'h2;
            2'b10:   sample_bytes = 3'h2;
            default: sample_bytes = 3'h4;
        endcase
    endfunction

    wire [7:0] play_fmt = regs_ff[creg_pkg::IDX_PFMT];
    wire [7:0] cap_fmt  = mode1 ? play_fmt : regs_ff[creg_pkg::IDX_CAPFMT];

    // ----------------------------------------
    // DMA request sequencing
    // ----------------------------------------
    logic       buf_in_rdy;
    logic       ch0_cap;
    logic [1:0] dma_done;

    // The host acks pair k and strobes once per byte
    assign dma_done[0] = (wr_rise | rd_rise) & cyc_dack_ff[0];
    assign dma_done[1] = (wr_rise | rd_rise) & cyc_dack_ff[1];

    wire dma_play_byte = wr_rise & cyc_dack_ff[0] & ~ch0_cap;
    wire dma_cap_byte  = rd_rise & ((cyc_dack_ff[0] & ch0_cap) | cyc_dack_ff[1]);

    // Only routing depends on the single-channel bit; sample
    // sizes and data paths are the same in both modes
    dma_channel_arbiter u_arb (
        .mclk_i       (mclk_i),
        .rst_b_i      (rst_b_i),
        .single_i     (single),
        .play_want_i  (play_want),
        .cap_want_i   (cap_want),
        .play_room_i  (buf_in_rdy),
        .cap_room_i   (cap_avail),
        .play_bytes_i (sample_bytes(play_fmt)),
        .cap_bytes_i  (sample_bytes(cap_fmt)),
        .done_i       (dma_done),
        .req_o        (drq_o),
        .ch0_cap_o    (ch0_cap)
    );

    // ----------------------------------------
    // Playback data path
    // ----------------------------------------
    // A full buffer keeps the playback request low, so DMA never
    // overruns it; a PIO writer must watch the ready status bit
    wire pb_push = dma_play_byte | wr_pio;

    two_entry_buffer u_pbuf (
        .mclk_i      (mclk_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (pb_push),
        .in_data_i   (cyc_data_ff),
        .in_ready_o  (buf_in_rdy),
        .out_valid_o (play_valid_o),
        .out_data_o  (play_data_o),
        .out_ready_i (play_ready_i)
    );

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    wire cap_dack_now = (~dack_b_s[0] & ch0_cap) | ~dack_b_s[1];

    wire [7:0] status_byte = {2'b00, cap_valid_i, core_err_i,
                              2'b00, buf_in_rdy, core_int_i};

    wire [7:0] win_rd =
        (eff_idx == creg_pkg::IDX_MODE)   ? {1'b1, mode_reg[6:5], 1'b0, creg_pkg::CODEC_ID} :
        (eff_idx == creg_pkg::IDX_COMPAT) ? creg_pkg::COMPAT_ID :
        ro_idx                            ? 8'h00 :
                                            regs_ff[eff_idx];

    wire [7:0] rd_byte =
        cap_dack_now                     ? cap_data_i :
        (ofs_now == creg_pkg::OFS_INDEX)  ? {1'b0, r0_ff} :
        (ofs_now == creg_pkg::OFS_WINDOW) ? win_rd :
        (ofs_now == creg_pkg::OFS_STATUS) ? status_byte :
                                            cap_data_i;

    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sd_o        <= 8'h00;
            sd_oe_o     <= 1'b0;
            cap_ready_o <= 1'b0;
            play_fmt_o  <= 8'h00;
            cap_fmt_o   <= 8'h00;
        end else begin
            sd_o        <= rd_byte;
            sd_oe_o     <= ~ior_b_s & (hit_now | cap_dack_now);
            cap_ready_o <= dma_cap_byte | rd_pio;
            play_fmt_o  <= play_fmt;
            cap_fmt_o   <= cap_fmt;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_MODE1_WRAP: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_win && mode1 && r0_ff[4:0] == 5'h19
        |=> regs_ff[creg_pkg::IDX_IFACE] == $past(cyc_data_ff))
        else $error("mode 1 index 25 did not alias index 9");

    AST_MODE1_HIDE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_win && mode1 && r0_ff[4:0] == creg_pkg::IDX_CAPFMT
        |=> $stable(regs_ff[creg_pkg::IDX_CAPFMT]))
        else $error("upper register written in mode 1");

    AST_MODE2_UPPER: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_win && cms == creg_pkg::CMS_MODE2 && r0_ff[4:0] == creg_pkg::IDX_CAPFMT
        |=> regs_ff[creg_pkg::IDX_CAPFMT] == $past(cyc_data_ff))
        else $error("upper register unreachable in mode 2");

    AST_EXT_LOCK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_win && !mode3 && eff_idx == creg_pkg::IDX_EXT
        |=> $stable(regs_ff[creg_pkg::IDX_EXT]))
        else $error("extended access written outside mode 3");

    AST_CMS_MODE2: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_win && eff_idx == creg_pkg::IDX_MODE && cyc_data_ff[6:5] == 2'b10
        |=> cms == creg_pkg::CMS_MODE2 ##1 !mode1)
        else $error("mode field 10 did not select mode 2");

    AST_CMS_MODE3: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_win && eff_idx == creg_pkg::IDX_MODE && cyc_data_ff[6:5] == 2'b11
        |=> mode3)
        else $error("mode field 11 did not select mode 3");

    AST_CAP_FMT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !mode1 |=> cap_fmt_o == $past(regs_ff[creg_pkg::IDX_CAPFMT]))
        else $error("capture format not taken from capture register");

    AST_PIO_PLAY: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_pio && buf_in_rdy |=> play_valid_o)
        else $error("PIO playback byte lost");

    AST_PTR_WRITE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_ptr |=> r0_ff == $past(cyc_data_ff[6:0]))
        else $error("index pointer write lost");

    AST_IFACE_SDC: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        wr_win && eff_idx == creg_pkg::IDX_IFACE
        |=> single == $past(cyc_data_ff[creg_pkg::IFC_SDC]))
        else $error("single-channel bit did not follow interface_config");

    AST_OE_IDLE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ior_b_s |=> !sd_oe_o)
        else $error("data bus driven without a read strobe");

    AST_STATUS_READ: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !ior_b_s && hit_now && ofs_now == creg_pkg::OFS_STATUS && !cap_dack_now
        |=> sd_o == $past(status_byte))
        else $error("status port read returned wrong byte");

    AST_WIN_READ: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !ior_b_s && hit_now && ofs_now == creg_pkg::OFS_WINDOW && !cap_dack_now
        |=> sd_o == $past(win_rd))
        else $error("window read returned wrong byte");

    AST_PIO_CAP_ACK: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        rd_pio |=> cap_ready_o)
        else $error("PIO capture read not acknowledged to the core");

    AST_CAP_FMT_MODE1: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        mode1 |=> cap_fmt_o == $past(play_fmt))
        else $error("mode 1 capture format differs from playback format");

    AST_FMT_SINGLE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        single |=> play_fmt_o == $past(play_fmt))
        else $error("single-channel mode disturbed the playback format");
endmodule
`default_nettype wire

// ==== verilog/creg_pkg.sv ====
`default_nettype none
package creg_pkg;
    // ----------------------------------------
    // Direct port offsets from the base
    // ----------------------------------------
    localparam logic [1:0] OFS_INDEX  = 2'h0;
    localparam logic [1:0] OFS_WINDOW = 2'h1;
    localparam logic [1:0] OFS_STATUS = 2'h2;
    localparam logic [1:0] OFS_PIO    = 2'h3;
    // ----------------------------------------
    // Indirect register indices
    // ----------------------------------------
    localparam logic [4:0] IDX_PFMT   = 5'h08;
    localparam logic [4:0] IDX_IFACE  = 5'h09;
    localparam logic [4:0] IDX_MODE   = 5'h0c;
    localparam logic [4:0] IDX_EXT    = 5'h17;
    localparam logic [4:0] IDX_COMPAT = 5'h19;
    localparam logic [4:0] IDX_RSV27  = 5'h1b;
    localparam logic [4:0] IDX_CAPFMT = 5'h1c;
    localparam logic [4:0] IDX_RSV29  = 5'h1d;
    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int IFC_PEN  = 0;
    localparam int IFC_CEN  = 1;
    localparam int IFC_SDC  = 2;
    localparam int IFC_PLAYBACK_BY_PROGRAMMED_IO = 6;
    localparam int IFC_CAPTURE_BY_PROGRAMMED_IO = 7;
    localparam int CMS_LSB  = 5;
    localparam int CMS_MSB  = 6;
    localparam int FMT_HI   = 7;
    localparam int FMT_LO   = 6;
    localparam int FMT_CL   = 5;
    localparam int FMT_SM   = 4;
    localparam logic [7:0] REG_RST   = 8'h00;
    localparam logic [6:0] R0_RST    = 7'h00;
    localparam logic [3:0] CODEC_ID  = 4'ha;  // Arbitrary value
    localparam logic [7:0] COMPAT_ID = 8'h05; // Arbitrary value
    typedef enum logic [1:0] {
        CMS_MODE1 = 2'b00,
        CMS_SPARE = 2'b01,
        CMS_MODE2 = 2'b10,
        CMS_MODE3 = 2'b11
    } compat_mode_select_e;
    typedef enum logic {
        CH_IDLE = 1'b0,
        CH_BUSY = 1'b1
    } chan_state_e;
endpackage
`default_nettype wire

// ==== verilog/dma_channel_arbiter.sv ====
`timescale 1ns/100ps
`default_nettype none
module dma_channel_arbiter (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       single_i,
    input  wire logic       play_want_i,
    input  wire logic       cap_want_i,
    input  wire logic       play_room_i,
    input  wire logic       cap_room_i,
    input  wire logic [2:0] play_bytes_i,
    input  wire logic [2:0] cap_bytes_i,
    input  wire logic [1:0] done_i,
    output logic [1:0]      req_o,
    output logic            ch0_cap_o
);
    logic       cap_own_ff;
    wire        start0 = single_i ? (play_want_i | cap_want_i) : play_want_i;
    wire        own0   = single_i & ~play_want_i;
    wire  [1:0] start  = {~single_i & cap_want_i, start0};
    wire  [1:0] room   = {cap_room_i, cap_own_ff ? cap_room_i : play_room_i};
    wire  [2:0] bytes0 = own0 ? cap_bytes_i : play_bytes_i;

    // ----------------------------------------
    // One sample sequencer per request pair
    // ----------------------------------------
    for (genvar k = 0; k < 2; k++) begin : g_ch
        creg_pkg::chan_state_e st_ff, nxt_st;
        logic [2:0] left_ff, nxt_left;
        logic       req_ff, nxt_req;
        always_comb begin
            nxt_st   = st_ff;
            nxt_left = left_ff;
            nxt_req  = req_ff;
            case (st_ff)
                creg_pkg::CH_IDLE: begin
                    if (start[k]) begin
                        nxt_st   = creg_pkg::CH_BUSY;
                        nxt_left = (k == 0) ? bytes0 : cap_bytes_i;
                    end
                end
                creg_pkg::CH_BUSY: begin
                    // Owner is fixed until the last byte: no interleave
                    if (req_ff && done_i[k]) begin
                        nxt_req  = 1'b0;
                        nxt_left = left_ff - 3'h1;
                        if (left_ff == 3'h1) begin
                            nxt_st = creg_pkg::CH_IDLE;
                        end
                    end else if (!req_ff) begin
                        nxt_req = room[k];
                    end
                end
                default: nxt_st = creg_pkg::CH_IDLE;
            endcase
        end
        always_ff @(posedge mclk_i) begin
            st_ff   <= rst_b_i ? nxt_st : creg_pkg::CH_IDLE;
            left_ff <= rst_b_i ? nxt_left : 3'h0;
            req_ff  <= rst_b_i & nxt_req;
        end
        assign req_o[k] = req_ff;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cap_own_ff <= 1'b0;
        end else if (g_ch[0].st_ff == creg_pkg::CH_IDLE && start0) begin
            cap_own_ff <= own0;
        end
    end
    assign ch0_cap_o = cap_own_ff;

    AST_REQ_HOLD: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        g_ch[0].req_ff && !done_i[0] |=> g_ch[0].req_ff)
        else $error("request dropped before its byte cycle");
    AST_ONE_DIR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        g_ch[1].st_ff == creg_pkg::CH_IDLE && single_i |=> g_ch[1].st_ff == creg_pkg::CH_IDLE)
        else $error("second channel started in single mode");
    AST_PLAY_FIRST: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        g_ch[0].st_ff == creg_pkg::CH_IDLE && single_i && play_want_i && cap_want_i
        |=> g_ch[0].st_ff == creg_pkg::CH_BUSY && !cap_own_ff)
        else $error("capture won over playback");
    AST_DUAL_ROUTE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        g_ch[0].st_ff == creg_pkg::CH_IDLE && start0 && !single_i |=> !cap_own_ff)
        else $error("capture placed on pair 0 in dual mode");
endmodule
`default_nettype wire

// ==== verilog/two_entry_buffer.sv ====
`timescale 1ns/100ps
`default_nettype none
module two_entry_buffer (
    input  wire logic       mclk_i,
    input  wire logic       rst_b_i,
    input  wire logic       in_valid_i,
    input  wire logic [7:0] in_data_i,
    output logic            in_ready_o,
    output logic            out_valid_o,
    output logic [7:0]      out_data_o,
    input  wire logic       out_ready_i
);
    logic [7:0] d0_ff, d1_ff, nxt_d0, nxt_d1;
    logic       v0_ff, v1_ff, nxt_v0, nxt_v1;
    wire        push = in_valid_i & ~v1_ff;
    wire        pop  = v0_ff & out_ready_i;

    // Head stays in d0 so the drain side always sees a flop
    always_comb begin
        nxt_d0 = d0_ff;
        nxt_d1 = d1_ff;
        nxt_v0 = v0_ff;
        nxt_v1 = v1_ff;
        if (pop && v1_ff) begin
            nxt_d0 = d1_ff;
            nxt_v1 = 1'b0;
        end else if (pop) begin
            nxt_v0 = push;
            nxt_d0 = push ? in_data_i : d0_ff;
        end else if (push && !v0_ff) begin
            nxt_v0 = 1'b1;
            nxt_d0 = in_data_i;
        end else if (push) begin
            nxt_v1 = 1'b1;
            nxt_d1 = in_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        d0_ff <= nxt_d0;
        d1_ff <= nxt_d1;
        v0_ff <= rst_b_i & nxt_v0;
        v1_ff <= rst_b_i & nxt_v1;
    end

    assign in_ready_o  = ~v1_ff;
    assign out_valid_o = v0_ff;
    assign out_data_o  = d0_ff;
endmodule
`default_nettype wire
